//--- dme_engine.sv
// DSP multiply/accumulate engine: shared 17x17 multiplier with scaler,
// 40-bit adder/subtracter, two accumulators, saturation, sticky flags and
// arithmetic warning trap request. Driven by the core decoder one
// instruction per cycle on the core clock; registers on a plain port.
//
// Operation
// - One instruction per cycle; clashing MCU multiply dropped
// - Operands widened to 17 bits by sign
// - 33-bit product sign-extended to 40 bits
// - Product scaled fractional 1.31 or integer
// - Control register selects sign and rounding
// - Clip enables bits 7,6; width bit 4
// - Separate memory write clip enable
// - MCU multiply gives 16 or 32 bits
// - Accumulator add/sub/negate need no memory data
// - One accumulator is source and destination
// - Load and add take shifter-scaled data
// - Adder zeroes one input, complements other
// - Add carry-in low; subtract complements, carry-in high
// - Guard flag when bits 39:32 differ
// - Guard flag plus enable requests trap
// - Clip flags sticky, software clear only
// - Unsaturated clip flag is bit 39 overflow
// - Combined guard and clip status bits
// - Super mode saturates to 9.31 limits
// - Normal mode saturates 1.31, no guard flags
// - Catastrophic overflow wraps, sets clip, traps
// - Sign select set means unsigned multiply
// - Fraction select set means integer multiply
// - Width select set means super saturation
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps

module dme_engine
  import dme_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_dsp_valid,
  input  wire dme_dsp_req_s i_dsp_req,
  input  wire logic         i_mcu_valid,
  input  wire dme_mcu_req_s i_mcu_req,
  input  wire logic [7:0]   i_addr,
  input  wire logic [31:0]  i_wr_data,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  output logic [31:0]       o_rd_data,
  output logic [31:0]       o_mcu_result,
  output logic              o_mcu_done,
  output logic              o_trap_req,
  output logic              o_round_mode_select,
  output logic              o_mem_write_clip_en,
  output logic [39:0]       o_first_accumulator,
  output logic [39:0]       o_second_accumulator
);

  // Architectural state
  logic [15:0] core_control_reg;
  logic [2:0]  trap_control_reg;
  logic [39:0] first_accumulator;
  logic [39:0] second_accumulator;
  logic        acc_a_guard_ovf;
  logic        acc_b_guard_ovf;
  logic        acc_a_clip_flag;
  logic        acc_b_clip_flag;

  // Control fields
  wire mult_sign_select  = core_control_reg[DME_CC_SIGN_SEL];
  wire acc_a_clip_en     = core_control_reg[DME_CC_CLIP_A];
  wire acc_b_clip_en     = core_control_reg[DME_CC_CLIP_B];
  wire clip_width_select = core_control_reg[DME_CC_WIDTH_SEL];
  wire frac_int_select   = core_control_reg[DME_CC_FRAC_INT];
  wire guard_trap_en_first  = trap_control_reg[DME_TC_GUARD_A];
  wire guard_trap_en_second = trap_control_reg[DME_TC_GUARD_B];
  wire catastrophic_trap_en = trap_control_reg[DME_TC_CATA];

  // Register port decode
  wire wr_core   = i_wr && (i_addr == DME_OFS_CORE_CTRL);
  wire wr_trap   = i_wr && (i_addr == DME_OFS_TRAP_CTRL);
  wire wr_status = i_wr && (i_addr == DME_OFS_STATUS);

  // Operation class decode
  dme_op_e op;
  assign op = i_dsp_req.op;
  wire uses_mult = (op == DME_OP_MPY) || (op == DME_OP_MPY_NEG) ||
                   (op == DME_OP_MAC) || (op == DME_OP_MSC) ||
                   (op == DME_OP_SQ_DIFF) || (op == DME_OP_SQ_DIFF_ACC);
  wire is_sq_diff = (op == DME_OP_SQ_DIFF) || (op == DME_OP_SQ_DIFF_ACC);
  wire dsp_mult = i_dsp_valid && uses_mult;
  wire adder_op = i_dsp_valid && (op != DME_OP_PREFETCH_WB);
  // A DSP instruction owns the engine; a separate MCU multiply is refused
  wire mcu_go = i_mcu_valid && !i_dsp_valid;

  // Difference for the square-of-difference ops, formed beside the multiply
  // Signed 17 bits whatever the sign select says
  wire [16:0] sq_diff = 17'({i_dsp_req.x[15], i_dsp_req.x} -
                            {i_dsp_req.y[15], i_dsp_req.y});

  // DSP operand widening: zero fill when unsigned, sign copy when signed
  wire [16:0] dsp_x17 = mult_sign_select ? {1'b0, i_dsp_req.x}
                                         : {i_dsp_req.x[15], i_dsp_req.x};
  wire [16:0] dsp_y17 = mult_sign_select ? {1'b0, i_dsp_req.y}
                                         : {i_dsp_req.y[15], i_dsp_req.y};

  // MCU operand widening; byte operands are unsigned low bytes
  wire [16:0] mcu_x17 = i_mcu_req.byte_mode ? {9'h000, i_mcu_req.x[7:0]} :
                        i_mcu_req.x_signed  ? {i_mcu_req.x[15], i_mcu_req.x} :
                                              {1'b0, i_mcu_req.x};
  wire [16:0] mcu_y17 = i_mcu_req.byte_mode ? {9'h000, i_mcu_req.y[7:0]} :
                        i_mcu_req.y_signed  ? {i_mcu_req.y[15], i_mcu_req.y} :
                                              {1'b0, i_mcu_req.y};

  // Shared multiplier input selection
  wire [16:0] mul_a = dsp_mult ? (is_sq_diff ? sq_diff : dsp_x17) : mcu_x17;
  wire [16:0] mul_b = dsp_mult ? (is_sq_diff ? sq_diff : dsp_y17) : mcu_y17;

  // 17x17 signed multiply and scaler
  wire signed [33:0] mul_full = $signed(mul_a) * $signed(mul_b);
  wire [32:0] prod_int  = mul_full[32:0];
  wire [32:0] prod_frac = {mul_full[31:0], 1'b0};
  wire [32:0] prod33 = frac_int_select ? prod_int : prod_frac;
  wire [39:0] prod40 = {{7{prod33[32]}}, prod33};

  // MCU multiply result: 16 bits for bytes, 32 bits for words
  wire [31:0] mcu_res = i_mcu_req.byte_mode ? {16'h0000, mul_full[15:0]}
                                            : mul_full[31:0];

  // Target and other accumulator selection
  wire [39:0] acc_tgt   = i_dsp_req.target ? second_accumulator : first_accumulator;
  wire [39:0] acc_other = i_dsp_req.target ? first_accumulator : second_accumulator;
  wire tgt_clip_en = i_dsp_req.target ? acc_b_clip_en : acc_a_clip_en;

  // Adder input steering per operation
  logic        zero_a;
  logic        subtract;
  logic [39:0] b_src;
  always_comb begin
    zero_a   = 1'b0;
    subtract = 1'b0;
    b_src    = 40'h00_0000_0000;
    case (op)
      DME_OP_CLR: begin
        zero_a = 1'b1;
      end
      DME_OP_MPY, DME_OP_SQ_DIFF: begin
        zero_a = 1'b1;
        b_src  = prod40;
      end
      DME_OP_MPY_NEG: begin
        zero_a   = 1'b1;
        subtract = 1'b1;
        b_src    = prod40;
      end
      DME_OP_MAC, DME_OP_SQ_DIFF_ACC: begin
        b_src = prod40;
      end
      DME_OP_MSC: begin
        subtract = 1'b1;
        b_src    = prod40;
      end
      DME_OP_ADD_ACC: begin
        b_src = acc_other;
      end
      DME_OP_SUB_ACC: begin
        subtract = 1'b1;
        b_src    = acc_other;
      end
      DME_OP_NEG_ACC: begin
        zero_a   = 1'b1;
        subtract = 1'b1;
        b_src    = acc_tgt;
      end
      DME_OP_LOAD: begin
        zero_a = 1'b1;
        b_src  = i_dsp_req.ext;
      end
      DME_OP_ADD_EXT: begin
        b_src = i_dsp_req.ext;
      end
      default: begin
        zero_a = 1'b0;
      end
    endcase
  end

  // 40-bit adder: optional zero side, true or complement other side
  wire [39:0] add_a  = zero_a ? 40'h00_0000_0000 : acc_tgt;
  wire [39:0] add_b  = subtract ? ~b_src : b_src;
  wire        add_ci = subtract;
  wire [39:0] sum = add_a + add_b + {39'h00_0000_0000, add_ci};

  // Overflow detection on the raw sum
  // Normal mode overflows once bits 39:31 stop agreeing
  wire ovf39 = (add_a[39] == add_b[39]) && (sum[39] != add_a[39]);
  wire ovf31 = ovf39 || !((&sum[39:31]) || !(|sum[39:31]));
  wire neg_dir = ovf39 ? add_a[39] : sum[39];

  // Saturation select and new flag values for the target
  wire sat_super = tgt_clip_en && clip_width_select && ovf39;
  wire sat_norm  = tgt_clip_en && !clip_width_select && ovf31;
  wire wrap_clip = !tgt_clip_en && ovf39;
  wire [39:0] acc_new = sat_super ? (neg_dir ? DME_SUPER_MIN : DME_SUPER_MAX) :
                        sat_norm  ? (neg_dir ? DME_NORM_MIN  : DME_NORM_MAX)  :
                                    sum;
  wire clip_new  = sat_super || sat_norm || wrap_clip;
  wire guard_raw = !((&acc_new[39:32]) || !(|acc_new[39:32]));
  wire guard_new = guard_raw && !(tgt_clip_en && !clip_width_select);

  // Write-enables per accumulator
  wire upd_a = adder_op && !i_dsp_req.target;
  wire upd_b = adder_op && i_dsp_req.target;

  // Software clear of clip flags: write one to clear
  wire clr_clip_a = wr_status && i_wr_data[DME_ST_CLIP_A];
  wire clr_clip_b = wr_status && i_wr_data[DME_ST_CLIP_B];

  // Combined status bits
  wire either_guard_ovf = acc_a_guard_ovf || acc_b_guard_ovf;
  wire either_clip_flag = acc_a_clip_flag || acc_b_clip_flag;

  // Trap request terms
  // Built from stored flags, so the registered request lags the op by two edges
  wire next_trap_req = (acc_a_guard_ovf && guard_trap_en_first) ||
                       (acc_b_guard_ovf && guard_trap_en_second) ||
                       (catastrophic_trap_en &&
                        ((acc_a_clip_flag && !acc_a_clip_en) ||
                         (acc_b_clip_flag && !acc_b_clip_en)));

  // Read data selection
  wire [31:0] status_word = {26'h000_0000, either_clip_flag, either_guard_ovf,
                             acc_b_clip_flag, acc_a_clip_flag,
                             acc_b_guard_ovf, acc_a_guard_ovf};
  logic [31:0] next_rd_data;
  always_comb begin
    if (!i_rd) begin
      next_rd_data = 32'h0000_0000;
    end else if (i_addr == DME_OFS_CORE_CTRL) begin
      next_rd_data = {16'h0000, core_control_reg};
    end else if (i_addr == DME_OFS_TRAP_CTRL) begin
      next_rd_data = {29'h0000_0000, trap_control_reg};
    end else if (i_addr == DME_OFS_STATUS) begin
      next_rd_data = status_word;
    end else if (i_addr == DME_OFS_FIRST_ACCUMULATOR_LO) begin
      next_rd_data = first_accumulator[31:0];
    end else if (i_addr == DME_OFS_FIRST_ACCUMULATOR_HI) begin
      next_rd_data = {24'h00_0000, first_accumulator[39:32]};
    end else if (i_addr == DME_OFS_SECOND_ACCUMULATOR_LO) begin
      next_rd_data = second_accumulator[31:0];
    end else if (i_addr == DME_OFS_SECOND_ACCUMULATOR_HI) begin
      next_rd_data = {24'h00_0000, second_accumulator[39:32]};
    end else begin
      next_rd_data = 32'h0000_0000;
    end
  end

  // Control registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      core_control_reg <= DME_CC_RESET;
      trap_control_reg <= DME_TC_RESET;
    end else begin
      if (wr_core) begin
        core_control_reg <= i_wr_data[15:0] & DME_CC_MASK;
      end
      if (wr_trap) begin
        trap_control_reg <= i_wr_data[2:0];
      end
    end
  end

  // First accumulator and its flags
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      first_accumulator <= DME_ACC_RESET;
      acc_a_guard_ovf   <= 1'b0;
      acc_a_clip_flag   <= 1'b0;
    end else begin
      if (upd_a) begin
        first_accumulator <= acc_new;
        acc_a_guard_ovf   <= guard_new;
      end
      // An op setting the flag beats a same-cycle clear
      if (upd_a && clip_new) begin
        acc_a_clip_flag <= 1'b1;
      end else if (clr_clip_a) begin
        acc_a_clip_flag <= 1'b0;
      end
    end
  end

  // Second accumulator and its flags
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      second_accumulator <= DME_ACC_RESET;
      acc_b_guard_ovf    <= 1'b0;
      acc_b_clip_flag    <= 1'b0;
    end else begin
      if (upd_b) begin
        second_accumulator <= acc_new;
        acc_b_guard_ovf    <= guard_new;
      end
      // Same priority as the first accumulator
      if (upd_b && clip_new) begin
        acc_b_clip_flag <= 1'b1;
      end else if (clr_clip_b) begin
        acc_b_clip_flag <= 1'b0;
      end
    end
  end

  // MCU multiply result and completion pulse
  // The result holds between accepted multiplies
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mcu_result <= 32'h0000_0000;
      o_mcu_done   <= 1'b0;
    end else begin
      o_mcu_done <= mcu_go;
      if (mcu_go) begin
        o_mcu_result <= mcu_res;
      end
    end
  end

  // Registered outputs: read data, trap request, mirrors
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data            <= 32'h0000_0000;
      o_trap_req           <= 1'b0;
      o_round_mode_select  <= DME_CC_RESET[DME_CC_ROUND_SEL];
      o_mem_write_clip_en  <= DME_CC_RESET[DME_CC_MEM_CLIP];
      o_first_accumulator  <= DME_ACC_RESET;
      o_second_accumulator <= DME_ACC_RESET;
    end else begin
      o_rd_data            <= next_rd_data;
      o_trap_req           <= next_trap_req;
      o_round_mode_select  <= core_control_reg[DME_CC_ROUND_SEL];
      o_mem_write_clip_en  <= core_control_reg[DME_CC_MEM_CLIP];
      o_first_accumulator  <= first_accumulator;
      o_second_accumulator <= second_accumulator;
    end
  end

endmodule // dme_engine

//--- dme_pkg.sv
// Package for the DSP multiply/accumulate engine: register map, control
// field positions, reset values, saturation limits and operation codes.
// Assumes one 100 MHz core clock shared by the engine and its decoder.
package dme_pkg;

  // Register byte offsets on the plain register port
  localparam logic [7:0] DME_OFS_CORE_CTRL = 8'h00;
  localparam logic [7:0] DME_OFS_TRAP_CTRL = 8'h04;
  localparam logic [7:0] DME_OFS_STATUS    = 8'h08;
  localparam logic [7:0] DME_OFS_FIRST_ACCUMULATOR_LO   = 8'h0C;
  localparam logic [7:0] DME_OFS_FIRST_ACCUMULATOR_HI   = 8'h10;
  localparam logic [7:0] DME_OFS_SECOND_ACCUMULATOR_LO   = 8'h14;
  localparam logic [7:0] DME_OFS_SECOND_ACCUMULATOR_HI   = 8'h18;

  // Core control register field positions
  localparam int DME_CC_SIGN_SEL  = 12;
  localparam int DME_CC_CLIP_A    = 7;
  localparam int DME_CC_CLIP_B    = 6;
  localparam int DME_CC_MEM_CLIP  = 5;
  localparam int DME_CC_WIDTH_SEL = 4;
  localparam int DME_CC_ROUND_SEL = 1;
  localparam int DME_CC_FRAC_INT  = 0;
  localparam logic [15:0] DME_CC_MASK  = 16'h10F3;
  localparam logic [15:0] DME_CC_RESET = 16'h0020;

  // Trap control register field positions
  localparam int DME_TC_GUARD_A = 0;
  localparam int DME_TC_GUARD_B = 1;
  localparam int DME_TC_CATA    = 2;
  localparam logic [2:0] DME_TC_RESET = 3'h0;

  // Status register field positions
  localparam int DME_ST_GUARD_A   = 0;
  localparam int DME_ST_GUARD_B   = 1;
  localparam int DME_ST_CLIP_A    = 2;
  localparam int DME_ST_CLIP_B    = 3;
  localparam int DME_ST_GUARD_ANY = 4;
  localparam int DME_ST_CLIP_ANY  = 5;

  // Saturation limits
  localparam logic [39:0] DME_SUPER_MAX = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] DME_SUPER_MIN = 40'h80_0000_0000;
  localparam logic [39:0] DME_NORM_MAX  = 40'h00_7FFF_FFFF;
  localparam logic [39:0] DME_NORM_MIN  = 40'h00_8000_0000;
  localparam logic [39:0] DME_ACC_RESET = 40'h00_0000_0000;

  // Engine operations
  typedef enum logic [3:0] {
    DME_OP_CLR, DME_OP_MPY, DME_OP_MPY_NEG, DME_OP_MAC, DME_OP_MSC,
    DME_OP_SQ_DIFF, DME_OP_SQ_DIFF_ACC, DME_OP_ADD_ACC, DME_OP_SUB_ACC,
    DME_OP_NEG_ACC, DME_OP_LOAD, DME_OP_ADD_EXT, DME_OP_PREFETCH_WB
  } dme_op_e;

  // One engine instruction
  typedef struct packed {
    dme_op_e     op;
    logic        target;    // 0 = first_accumulator, 1 = second_accumulator
    logic [15:0] x;
    logic [15:0] y;
    logic [39:0] ext;       // Shifter-scaled data for load and add
  } dme_dsp_req_s;

  // One MCU multiply instruction
  typedef struct packed {
    logic        byte_mode;
    logic        x_signed;
    logic        y_signed;
    logic [15:0] x;
    logic [15:0] y;
  } dme_mcu_req_s;

endpackage

//--- dme_engine_chk.sv
// Checker for the DSP multiply/accumulate engine, bound to its top ports.
// Assumes one core clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module dme_engine_chk
  import dme_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_rst,
  input wire logic         i_dsp_valid,
  input wire dme_dsp_req_s i_dsp_req,
  input wire logic         i_mcu_valid,
  input wire dme_mcu_req_s i_mcu_req,
  input wire logic [7:0]   i_addr,
  input wire logic [31:0]  i_wr_data,
  input wire logic         i_wr,
  input wire logic [31:0]  o_mcu_result,
  input wire logic         o_mcu_done,
  input wire logic         o_trap_req,
  input wire logic         o_round_mode_select,
  input wire logic         o_mem_write_clip_en,
  input wire logic [39:0]  o_first_accumulator,
  input wire logic [39:0]  o_second_accumulator
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // MCU multiply handshake and products
  property p_mcu_refused;
    i_mcu_valid && i_dsp_valid |=> !o_mcu_done;
  endproperty
  a_mcu_refused: assert property (p_mcu_refused) else $error("mcu multiply not dropped");
  property p_mcu_done;
    i_mcu_valid && !i_dsp_valid |=> o_mcu_done;
  endproperty
  a_mcu_done: assert property (p_mcu_done) else $error("mcu done missing");
  property p_mcu_byte;
    i_mcu_valid && !i_dsp_valid && i_mcu_req.byte_mode |=>
      o_mcu_result == 32'($past(i_mcu_req.x[7:0])) * 32'($past(i_mcu_req.y[7:0]));
  endproperty
  a_mcu_byte: assert property (p_mcu_byte) else $error("byte product wrong");
  property p_mcu_word;
    i_mcu_valid && !i_dsp_valid && !i_mcu_req.byte_mode && i_mcu_req.x_signed
      && i_mcu_req.y_signed |=> o_mcu_result ==
      32'($signed($past(i_mcu_req.x))) * 32'($signed($past(i_mcu_req.y)));
  endproperty
  a_mcu_word: assert property (p_mcu_word) else $error("word product wrong");
  property p_mcu_hold;
    !o_mcu_done |-> $stable(o_mcu_result);
  endproperty
  a_mcu_hold: assert property (p_mcu_hold) else $error("mcu result moved");

  // Accumulator path
  property p_load;
    i_dsp_valid && i_dsp_req.op == DME_OP_LOAD && !i_dsp_req.target
      && (i_dsp_req.ext[39:31] == 9'h000 || i_dsp_req.ext[39:31] == 9'h1FF)
      |-> ##2 o_first_accumulator == $past(i_dsp_req.ext, 2);
  endproperty
  a_load: assert property (p_load) else $error("load value wrong");
  property p_clr_other;
    i_dsp_valid && i_dsp_req.op == DME_OP_CLR && i_dsp_req.target |-> ##2
      o_second_accumulator == 40'h00_0000_0000
      && o_first_accumulator == $past(o_first_accumulator);
  endproperty
  a_clr_other: assert property (p_clr_other) else $error("clear hit wrong acc");
  property p_mpy_ext;
    i_dsp_valid && i_dsp_req.op == DME_OP_MPY && !i_dsp_req.target |-> ##2
      o_first_accumulator[39:32] == {8{o_first_accumulator[32]}};
  endproperty
  a_mpy_ext: assert property (p_mpy_ext) else $error("product not extended");

  // Control mirrors
  property p_round_mirror;
    i_wr && i_addr == DME_OFS_CORE_CTRL |-> ##2
      o_round_mode_select == $past(i_wr_data[DME_CC_ROUND_SEL], 2);
  endproperty
  a_round_mirror: assert property (p_round_mirror) else $error("round select wrong");
  property p_clip_mirror;
    i_wr && i_addr == DME_OFS_CORE_CTRL |-> ##2
      o_mem_write_clip_en == $past(i_wr_data[DME_CC_MEM_CLIP], 2);
  endproperty
  a_clip_mirror: assert property (p_clip_mirror) else $error("write clip wrong");

  // Main scenarios reached
  c_mac: cover property (i_dsp_valid && i_dsp_req.op == DME_OP_MAC);
  c_refused: cover property (i_mcu_valid && i_dsp_valid);
  c_trap: cover property ($rose(o_trap_req));
endmodule // dme_engine_chk

bind dme_engine dme_engine_chk u_dme_engine_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_dsp_valid(i_dsp_valid), .i_dsp_req(i_dsp_req),
  .i_mcu_valid(i_mcu_valid), .i_mcu_req(i_mcu_req), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr(i_wr), .o_mcu_result(o_mcu_result),
  .o_mcu_done(o_mcu_done), .o_trap_req(o_trap_req),
  .o_round_mode_select(o_round_mode_select), .o_mem_write_clip_en(o_mem_write_clip_en),
  .o_first_accumulator(o_first_accumulator), .o_second_accumulator(o_second_accumulator));

//--- dme_decoder_model.sv
// Model of the core decoder issuing DSP and MCU instructions.
// Assumes the testbench calls its tasks; requests change after edges.
`timescale 1ns/1ps
module dme_decoder_model
  import dme_pkg::*;
(
  input  wire logic    i_clk,
  output dme_dsp_req_s o_dsp_req,
  output logic         o_dsp_valid,
  output dme_mcu_req_s o_mcu_req,
  output logic         o_mcu_valid
);
  // Idle at time zero
  initial begin
    o_dsp_valid = 1'b0;
    o_mcu_valid = 1'b0;
    o_dsp_req   = '0;
    o_mcu_req   = '0;
  end

  // One DSP instruction per cycle; fields scrambled once released
  task automatic dsp(input dme_op_e op, input logic t, input logic [15:0] x,
                     input logic [15:0] y, input logic [39:0] e);
    @(posedge i_clk);
    o_dsp_req   <= '{op, t, x, y, e};
    o_dsp_valid <= 1'b1;
    @(posedge i_clk);
    o_dsp_valid <= 1'b0;
    o_dsp_req   <= dme_dsp_req_s'(~o_dsp_req);
  endtask

  // MCU multiply, optionally colliding with a DSP instruction
  task automatic mcu(input logic [2:0] m, input logic [15:0] x, input logic [15:0] y,
                     input logic clash);
    @(posedge i_clk);
    o_mcu_req   <= '{m[2], m[1], m[0], x, y};
    o_mcu_valid <= 1'b1;
    o_dsp_req   <= '{DME_OP_PREFETCH_WB, 1'b0, x, y, 40'h00_0000_0000};
    o_dsp_valid <= clash;
    @(posedge i_clk);
    o_mcu_valid <= 1'b0;
    o_dsp_valid <= 1'b0;
    o_mcu_req   <= dme_mcu_req_s'(~o_mcu_req);
  endtask
endmodule // dme_decoder_model

//--- dme_engine_test.sv
// Testbench for the DSP multiply/accumulate engine: the decoder model
// issues instructions; assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module dme_engine_test
  import dme_pkg::*;
;
  localparam logic [39:0] ZERO = 40'h00_0000_0000;
  logic         i_clk = 1'b0;
  logic         i_rst = 1'b1;
  logic         dsp_valid;
  logic         mcu_valid;
  dme_dsp_req_s dsp_req;
  dme_mcu_req_s mcu_req;
  logic [7:0]   addr = 8'h00;
  logic [31:0]  wdata = 32'h0000_0000;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic [31:0]  rdata;
  logic [31:0]  mres;
  logic         done;
  logic         trap;
  logic         rnd;
  logic         mclip;
  logic [39:0]  acc_a;
  logic [39:0]  acc_b;
  int           miscompares = 0;
  int           checked = 0;

  // Core clock
  always #5 i_clk = ~i_clk;

  // Decoder model and engine
  dme_decoder_model u_dme_decoder_model (
    .i_clk(i_clk), .o_dsp_req(dsp_req), .o_dsp_valid(dsp_valid),
    .o_mcu_req(mcu_req), .o_mcu_valid(mcu_valid));
  dme_engine u_dme_engine (
    .i_clk(i_clk), .i_rst(i_rst), .i_dsp_valid(dsp_valid), .i_dsp_req(dsp_req),
    .i_mcu_valid(mcu_valid), .i_mcu_req(mcu_req), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .o_mcu_result(mres), .o_mcu_done(done),
    .o_trap_req(trap), .o_round_mode_select(rnd), .o_mem_write_clip_en(mclip),
    .o_first_accumulator(acc_a), .o_second_accumulator(acc_b));

  // Shared compare, register cycles and instruction helpers
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic dop(input dme_op_e op, input logic t, input logic [15:0] x,
                     input logic [15:0] y, input logic [39:0] e, input logic [39:0] x_acc);
    u_dme_decoder_model.dsp(op, t, x, y, e);
    @(posedge i_clk);
    #1 chk(t ? acc_b : acc_a, x_acc);
  endtask
  task automatic aop(input dme_op_e op, input logic t, input logic [39:0] e,
                     input logic [39:0] x_acc);
    dop(op, t, 16'h0000, 16'h0000, e, x_acc);
  endtask
  task automatic mop(input logic [2:0] m, input logic [15:0] x, input logic [15:0] y,
                     input logic c, input logic [31:0] e);
    u_dme_decoder_model.mcu(m, x, y, c);
    #1 chk({done, mres}, {~c, e});
  endtask

  // Scenarios
  task automatic t_reset;
    rchk(DME_OFS_CORE_CTRL, 32'h0000_0020);
    rchk(DME_OFS_TRAP_CTRL, 32'h0000_0000);
    rchk(DME_OFS_STATUS, 32'h0000_0000);
    rchk(8'h1C, 32'h0000_0000);
    chk(mclip, 1'b1);
  endtask
  task automatic t_ctrl;
    wreg(DME_OFS_CORE_CTRL, 32'hFFFF_FFFF);
    rchk(DME_OFS_CORE_CTRL, 32'h0000_10F3);
    chk(rnd, 1'b1);
    wreg(DME_OFS_CORE_CTRL, 32'h0000_0000);
    @(posedge i_clk);
    #1 chk(mclip, 1'b0);
  endtask
  task automatic t_mult;
    dop(DME_OP_MPY, 1'b0, 16'h4000, 16'h4000, ZERO, 40'h00_2000_0000);
    wreg(DME_OFS_CORE_CTRL, 32'h0000_0001);
    dop(DME_OP_MPY, 1'b0, 16'h8000, 16'h7FFF, ZERO, 40'hFF_C000_8000);
    wreg(DME_OFS_CORE_CTRL, 32'h0000_1001);
    dop(DME_OP_MPY, 1'b1, 16'h8000, 16'h7FFF, ZERO, 40'h00_3FFF_8000);
    dop(DME_OP_SQ_DIFF, 1'b0, 16'h0002, 16'h0005, ZERO, 40'h00_0000_0009);
    dop(DME_OP_SQ_DIFF_ACC, 1'b0, 16'h0002, 16'h0005, ZERO, 40'h00_0000_0012);
    dop(DME_OP_MPY_NEG, 1'b1, 16'h0002, 16'h0003, ZERO, 40'hFF_FFFF_FFFA);
    dop(DME_OP_MSC, 1'b0, 16'h0001, 16'h0002, ZERO, 40'h00_0000_0010);
  endtask
  task automatic t_accops;
    aop(DME_OP_LOAD, 1'b0, 40'h00_0000_0005, 40'h00_0000_0005);
    aop(DME_OP_LOAD, 1'b1, 40'h00_0000_0003, 40'h00_0000_0003);
    aop(DME_OP_SUB_ACC, 1'b0, ZERO, 40'h00_0000_0002);
    aop(DME_OP_ADD_ACC, 1'b1, ZERO, 40'h00_0000_0005);
    aop(DME_OP_NEG_ACC, 1'b0, ZERO, 40'hFF_FFFF_FFFE);
    aop(DME_OP_ADD_EXT, 1'b0, 40'h00_0000_0003, 40'h00_0000_0001);
    aop(DME_OP_CLR, 1'b1, ZERO, ZERO);
    chk(acc_a, 40'h00_0000_0001);
    aop(DME_OP_PREFETCH_WB, 1'b0, ZERO, 40'h00_0000_0001);
  endtask
  task automatic t_guard;
    wreg(DME_OFS_TRAP_CTRL, 32'h0000_0001);
    aop(DME_OP_LOAD, 1'b0, ZERO, ZERO);
    dop(DME_OP_MAC, 1'b0, 16'hFFFF, 16'hFFFF, ZERO, 40'h00_FFFE_0001);
    dop(DME_OP_MAC, 1'b0, 16'hFFFF, 16'hFFFF, ZERO, 40'h01_FFFC_0002);
    rchk(DME_OFS_STATUS, 32'h0000_0011);
    chk(trap, 1'b1);
    dop(DME_OP_MSC, 1'b0, 16'hFFFF, 16'hFFFF, ZERO, 40'h00_FFFE_0001);
    rchk(DME_OFS_STATUS, 32'h0000_0000);
    chk(trap, 1'b0);
  endtask
  task automatic t_cata;
    wreg(DME_OFS_CORE_CTRL, 32'h0000_0001);
    wreg(DME_OFS_TRAP_CTRL, 32'h0000_0004);
    aop(DME_OP_LOAD, 1'b0, DME_SUPER_MAX, DME_SUPER_MAX);
    aop(DME_OP_ADD_EXT, 1'b0, 40'h00_0000_0001, DME_SUPER_MIN);
    rchk(DME_OFS_STATUS, 32'h0000_0035);
    chk(trap, 1'b1);
    aop(DME_OP_LOAD, 1'b0, ZERO, ZERO);
    rchk(DME_OFS_STATUS, 32'h0000_0024);
    wreg(DME_OFS_STATUS, 32'h0000_0004);
    rchk(DME_OFS_STATUS, 32'h0000_0000);
    chk(trap, 1'b0);
  endtask
  task automatic t_super;
    wreg(DME_OFS_CORE_CTRL, 32'h0000_0091);
    aop(DME_OP_LOAD, 1'b0, DME_SUPER_MAX, DME_SUPER_MAX);
    aop(DME_OP_ADD_EXT, 1'b0, 40'h00_0000_0001, DME_SUPER_MAX);
    aop(DME_OP_LOAD, 1'b0, DME_SUPER_MIN, DME_SUPER_MIN);
    aop(DME_OP_ADD_EXT, 1'b0, 40'hFF_FFFF_FFFF, DME_SUPER_MIN);
    aop(DME_OP_LOAD, 1'b1, DME_SUPER_MAX, DME_SUPER_MAX);
    aop(DME_OP_ADD_EXT, 1'b1, 40'h00_0000_0001, DME_SUPER_MIN);
    rchk(DME_OFS_STATUS, 32'h0000_003F);
    wreg(DME_OFS_STATUS, 32'h0000_000C);
  endtask
  task automatic t_norm;
    wreg(DME_OFS_CORE_CTRL, 32'h0000_0081);
    aop(DME_OP_LOAD, 1'b0, DME_NORM_MAX, DME_NORM_MAX);
    aop(DME_OP_ADD_EXT, 1'b0, 40'h00_0000_0001, DME_NORM_MAX);
    rchk(DME_OFS_STATUS, 32'h0000_0036);
    aop(DME_OP_LOAD, 1'b0, 40'hFF_8000_0000, 40'hFF_8000_0000);
    aop(DME_OP_ADD_EXT, 1'b0, 40'hFF_FFFF_FFFF, DME_NORM_MIN);
  endtask
  task automatic t_mcu;
    mop(3'b100, 16'h12FF, 16'h34FF, 1'b0, 32'h0000_FE01);
    mop(3'b011, 16'hFFFF, 16'h0002, 1'b0, 32'hFFFF_FFFE);
    mop(3'b000, 16'hFFFF, 16'hFFFF, 1'b0, 32'hFFFE_0001);
    mop(3'b001, 16'hFFFF, 16'hFFFF, 1'b0, 32'hFFFF_0001);
    mop(3'b011, 16'h0003, 16'h0003, 1'b1, 32'hFFFF_0001);
  endtask

  // Verdict and end of run
  task automatic give_verdict;
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence after reset
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_ctrl;
    t_mult;
    t_accops;
    t_guard;
    t_cata;
    t_super;
    t_norm;
    t_mcu;
    give_verdict;
  end

  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge i_clk);
    miscompares++;
    give_verdict;
  end
endmodule // dme_engine_test
